// ==== core/isf_status.sv ====
// interrupt status flags, transmit fifo and read request clock hold
`timescale 1ns/100ps
module isf_status (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // register access
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [31:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    // events and levels from the bus controller core
    input wire logic core_start_seen,
    input wire logic core_stop_seen,
    input wire logic core_busy,
    input wire logic core_slave_tx_nack,
    input wire logic core_tx_abort,
    input wire logic [15:0] core_abort_cause,
    input wire logic core_read_request,
    input wire logic core_tx_pop,
    // towards the core and the clock line
    output logic [7:0] tx_head,
    output logic [5:0] tx_level,
    output logic tx_flushed,
    output logic internal_enable_signal,
    output logic scl_hold_low,
    output logic [15:0] masked_interrupt_status
);
    logic controller_enable_bit;
    logic [4:0] transmit_threshold_reg;
    logic [15:0] interrupt_mask_reg;
    logic [15:0] abort_cause_reg;
    logic start_seen_flag;
    logic stop_seen_flag;
    logic activity_flag;
    logic tx_done_flag;
    logic transmit_abort_flag;
    logic read_request_flag;
    logic tx_low_flag;
    logic tx_over_flag;
    logic [7:0] fifo_mem [isf_pkg::FIFO_DEPTH];
    logic [4:0] wr_ptr;
    logic [4:0] rd_ptr;
    logic [15:0] raw_status;

    function automatic logic hit(input logic [31:0] a, input logic [31:0] target);
        hit = (a == target);
    endfunction : hit

    wire rd_combined = reg_rd && hit(reg_addr, isf_pkg::ADDR_CLR_COMBINED);
    wire rd_clr_act = reg_rd && hit(reg_addr, isf_pkg::ADDR_CLR_ACTIVITY);
    wire rd_clr_abort = reg_rd && hit(reg_addr, isf_pkg::ADDR_CLR_TX_ABORT);
    wire rd_clr_rdreq = reg_rd && hit(reg_addr, isf_pkg::ADDR_CLR_RD_REQ);
    wire wr_data = reg_wr && hit(reg_addr, isf_pkg::ADDR_DATA_CMD);
    // fifo is held flushed while disabled or while an abort is pending
    wire flush = !controller_enable_bit || transmit_abort_flag;
    wire fifo_full = (tx_level == isf_pkg::FIFO_FULL_LVL);
    wire push = wr_data && !flush && !fifo_full;
    wire pop = core_tx_pop && !flush && (tx_level != isf_pkg::LVL_ZERO);

    // control registers
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            controller_enable_bit <= 1'b0;
            transmit_threshold_reg <= isf_pkg::THRESH_RESET;
            interrupt_mask_reg <= isf_pkg::MASK_RESET;
        end else if (reg_wr) begin
            if (hit(reg_addr, isf_pkg::ADDR_ENABLE)) begin
                controller_enable_bit <= reg_wdata[0];
            end
            if (hit(reg_addr, isf_pkg::ADDR_TX_THRESH)) begin
                transmit_threshold_reg <= reg_wdata[4:0];
            end
            if (hit(reg_addr, isf_pkg::ADDR_INTR_MASK)) begin
                interrupt_mask_reg <= reg_wdata & isf_pkg::STAT_USED;
            end
        end
    end

    // internal enable falls only once the state machines are idle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            internal_enable_signal <= 1'b0;
        end else begin
            internal_enable_signal <= controller_enable_bit
                || (internal_enable_signal && core_busy);
        end
    end

    // transmit fifo storage and pointers
    always_ff @(posedge clock) begin
        if (push) begin
            fifo_mem[wr_ptr] <= reg_wdata[7:0];
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            tx_level <= isf_pkg::LVL_ZERO;
        end else if (flush) begin
            wr_ptr <= '0; // R8 R15
            rd_ptr <= '0;
            tx_level <= isf_pkg::LVL_ZERO;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + isf_pkg::PTR_ONE;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + isf_pkg::PTR_ONE;
            end
            if (push && !pop) begin
                tx_level <= tx_level + isf_pkg::LVL_ONE;
            end else if (pop && !push) begin
                tx_level <= tx_level - isf_pkg::LVL_ONE;
            end
        end
    end

    // head word lags the pointer by one edge
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_head <= 8'h00;
            tx_flushed <= 1'b1;
        end else begin
            tx_head <= fifo_mem[rd_ptr];
            tx_flushed <= flush;
        end
    end

    // bus condition flags, cleared by the combined clear or disable
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            start_seen_flag <= 1'b0;
            stop_seen_flag <= 1'b0;
            tx_done_flag <= 1'b0;
        end else begin
            if (core_start_seen) begin
                start_seen_flag <= 1'b1; // R1
            end else if (rd_combined || !internal_enable_signal) begin
                start_seen_flag <= 1'b0;
            end
            if (core_stop_seen) begin
                stop_seen_flag <= 1'b1; // R2
            end else if (rd_combined || !internal_enable_signal) begin
                stop_seen_flag <= 1'b0;
            end
            if (core_slave_tx_nack) begin
                tx_done_flag <= 1'b1; // R5
            end else if (rd_combined || !internal_enable_signal) begin
                tx_done_flag <= 1'b0;
            end
        end
    end

    // sticky activity; a busy core wins over a clear in the same cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            activity_flag <= 1'b0; // R4
        end else if (core_busy) begin
            activity_flag <= 1'b1; // R3
        end else if (rd_combined || rd_clr_act || !internal_enable_signal) begin
            activity_flag <= 1'b0; // R4
        end
    end

    // transmit abort with its cause
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            transmit_abort_flag <= 1'b0;
            abort_cause_reg <= isf_pkg::CAUSE_RESET;
        end else if (core_tx_abort) begin
            transmit_abort_flag <= 1'b1; // R6
            abort_cause_reg <= core_abort_cause; // R7
        end else if (rd_clr_abort || rd_combined) begin
            transmit_abort_flag <= 1'b0; // R8
            abort_cause_reg <= isf_pkg::CAUSE_RESET;
        end
    end

    // read request and the clock hold that goes with it
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            read_request_flag <= 1'b0;
            scl_hold_low <= 1'b0;
        end else if (core_read_request) begin
            read_request_flag <= 1'b1; // R9
            scl_hold_low <= 1'b1; // R10
        end else if (rd_clr_rdreq || rd_combined) begin
            read_request_flag <= 1'b0; // R12
            scl_hold_low <= 1'b0;
        end
    end

    // level and overflow flags
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            tx_low_flag <= 1'b0;
            tx_over_flag <= 1'b0;
        end else begin
            // flushed level reads zero, so low follows the internal enable
            tx_low_flag <= internal_enable_signal
                && (tx_level <= {1'b0, transmit_threshold_reg}); // R13 R14 R15 R16
            if (wr_data && !flush && fifo_full) begin
                tx_over_flag <= 1'b1; // R17
            end else if (!internal_enable_signal || rd_combined) begin
                tx_over_flag <= 1'b0; // R18
            end
        end
    end

    always_comb begin
        raw_status = isf_pkg::WORD_ZERO;
        raw_status[isf_pkg::BIT_START] = start_seen_flag;
        raw_status[isf_pkg::BIT_STOP] = stop_seen_flag;
        raw_status[isf_pkg::BIT_ACTIVITY] = activity_flag;
        raw_status[isf_pkg::BIT_TX_DONE] = tx_done_flag;
        raw_status[isf_pkg::BIT_TX_ABORT] = transmit_abort_flag;
        raw_status[isf_pkg::BIT_RD_REQ] = read_request_flag;
        raw_status[isf_pkg::BIT_TX_LOW] = tx_low_flag;
        raw_status[isf_pkg::BIT_TX_OVER] = tx_over_flag;
    end

    // masked view, also exported; status registers ignore writes
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            masked_interrupt_status <= isf_pkg::WORD_ZERO; // R20
        end else begin
            masked_interrupt_status <= raw_status & interrupt_mask_reg; // R19
        end
    end

    // read data one edge after the strobe; unmapped reads give zero
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            reg_rdata <= isf_pkg::WORD_ZERO;
        end else if (reg_rd) begin
            case (reg_addr)
                isf_pkg::ADDR_MASKED_STAT: reg_rdata <= raw_status & interrupt_mask_reg;
                isf_pkg::ADDR_RAW_STAT: reg_rdata <= raw_status;
                isf_pkg::ADDR_INTR_MASK: reg_rdata <= interrupt_mask_reg;
                isf_pkg::ADDR_ENABLE: reg_rdata <= {15'h0000, controller_enable_bit};
                isf_pkg::ADDR_TX_THRESH: reg_rdata <= {11'h000, transmit_threshold_reg};
                isf_pkg::ADDR_ABORT_CAUSE: reg_rdata <= abort_cause_reg;
                isf_pkg::ADDR_CLR_COMBINED: reg_rdata <= {15'h0000, |raw_status};
                isf_pkg::ADDR_CLR_ACTIVITY: reg_rdata <= {15'h0000, activity_flag};
                isf_pkg::ADDR_CLR_TX_ABORT: reg_rdata <= {15'h0000, transmit_abort_flag};
                isf_pkg::ADDR_CLR_RD_REQ: reg_rdata <= {15'h0000, read_request_flag};
                default: reg_rdata <= isf_pkg::WORD_ZERO;
            endcase
        end else begin
            reg_rdata <= isf_pkg::WORD_ZERO;
        end
    end

    chk_start_sets: assert property (@(posedge clock) disable iff (!rst_n) // R1
        core_start_seen |=> start_seen_flag)
        else $error("start flag missed");
    chk_stop_sets: assert property (@(posedge clock) disable iff (!rst_n) // R2
        core_stop_seen |=> stop_seen_flag)
        else $error("stop flag missed");
    chk_activity_sticks: assert property (@(posedge clock) disable iff (!rst_n) // R3
        activity_flag && !core_busy && internal_enable_signal && !rd_combined
        && !rd_clr_act |=> activity_flag)
        else $error("activity flag dropped on its own");
    chk_activity_clear: assert property (@(posedge clock) disable iff (!rst_n) // R4
        rd_clr_act && !core_busy |=> !activity_flag)
        else $error("activity clear read ignored");
    chk_done_sets: assert property (@(posedge clock) disable iff (!rst_n) // R5
        core_slave_tx_nack |=> tx_done_flag)
        else $error("transmit done flag missed");
    chk_abort_cause: assert property (@(posedge clock) disable iff (!rst_n) // R7
        core_tx_abort |=> transmit_abort_flag && abort_cause_reg == $past(core_abort_cause))
        else $error("abort cause not latched");
    chk_abort_flush: assert property (@(posedge clock) disable iff (!rst_n) // R8
        transmit_abort_flag |=> tx_level == isf_pkg::LVL_ZERO)
        else $error("fifo not flushed under abort");
    chk_rdreq_hold: assert property (@(posedge clock) disable iff (!rst_n) // R10
        read_request_flag |-> scl_hold_low)
        else $error("clock not held for read request");
    chk_rdreq_clear: assert property (@(posedge clock) disable iff (!rst_n) // R12
        rd_clr_rdreq && !core_read_request |=> !read_request_flag)
        else $error("read request not cleared");
    chk_low_level: assert property (@(posedge clock) disable iff (!rst_n) // R13
        internal_enable_signal && tx_level <= {1'b0, transmit_threshold_reg} |=> tx_low_flag)
        else $error("level low flag missed");
    chk_low_idle: assert property (@(posedge clock) disable iff (!rst_n) // R16
        !internal_enable_signal |=> !tx_low_flag)
        else $error("level low flag set while idle");
    chk_over_sets: assert property (@(posedge clock) disable iff (!rst_n) // R17
        wr_data && !flush && fifo_full && !core_tx_pop
        |=> tx_over_flag && tx_level == isf_pkg::FIFO_FULL_LVL)
        else $error("overflow flag missed");
    chk_over_drop: assert property (@(posedge clock) disable iff (!rst_n) // R18
        !internal_enable_signal && !wr_data |=> !tx_over_flag)
        else $error("overflow kept after enable drop");
    chk_mask_gate: assert property (@(posedge clock) disable iff (!rst_n) // R19
        1'b1 |=> masked_interrupt_status == ($past(raw_status) & $past(interrupt_mask_reg)))
        else $error("masked status wrong");
    chk_abort_flushed: assert property (@(posedge clock) disable iff (!rst_n) // R8
        transmit_abort_flag |=> tx_flushed)
        else $error("fifo not marked flushed under abort");
    chk_abort_clear: assert property (@(posedge clock) disable iff (!rst_n) // R8
        rd_clr_abort && !core_tx_abort |=> !transmit_abort_flag && ~|abort_cause_reg)
        else $error("abort clear read ignored");
    chk_rdreq_sets: assert property (@(posedge clock) disable iff (!rst_n) // R9
        core_read_request |=> read_request_flag && scl_hold_low)
        else $error("read request flag missed");
    chk_low_high: assert property (@(posedge clock) disable iff (!rst_n) // R14
        tx_level > {1'b0, transmit_threshold_reg} |=> !tx_low_flag)
        else $error("level low flag kept above threshold");
    chk_disable_flush: assert property (@(posedge clock) disable iff (!rst_n) // R15
        !controller_enable_bit |=> tx_level == isf_pkg::LVL_ZERO)
        else $error("fifo not flushed while disabled");
    chk_enable_hold: assert property (@(posedge clock) disable iff (!rst_n) // R15
        !controller_enable_bit && core_busy && internal_enable_signal |=> internal_enable_signal)
        else $error("internal enable dropped while busy");
    chk_enable_drop: assert property (@(posedge clock) disable iff (!rst_n) // R16
        !controller_enable_bit && !core_busy |=> !internal_enable_signal)
        else $error("internal enable kept while idle");
    chk_over_keeps: assert property (@(posedge clock) disable iff (!rst_n) // R18
        tx_over_flag && internal_enable_signal && !rd_combined |=> tx_over_flag)
        else $error("overflow flag dropped early");
    chk_start_clear: assert property (@(posedge clock) disable iff (!rst_n) // R1
        rd_combined && !core_start_seen |=> !start_seen_flag)
        else $error("start flag not cleared");
    chk_done_clear: assert property (@(posedge clock) disable iff (!rst_n) // R5
        rd_combined && !core_slave_tx_nack |=> !tx_done_flag)
        else $error("transmit done flag not cleared");
    chk_activity_disable: assert property (@(posedge clock) disable iff (!rst_n) // R4
        !internal_enable_signal && !core_busy |=> !activity_flag)
        else $error("activity kept while disabled");
    chk_status_read: assert property (@(posedge clock) disable iff (!rst_n) // R19
        reg_rd && reg_addr == isf_pkg::ADDR_MASKED_STAT
        |=> reg_rdata == ($past(raw_status) & $past(interrupt_mask_reg)))
        else $error("masked status read wrong");
    chk_reset_zero: assert property (@(posedge clock) // R20
        !rst_n |=> raw_status == isf_pkg::WORD_ZERO
        && masked_interrupt_status == isf_pkg::WORD_ZERO)
        else $error("flags not zero after reset");
    chk_level_cap: assert property (@(posedge clock) disable iff (!rst_n) // R17
        tx_level <= isf_pkg::FIFO_FULL_LVL)
        else $error("fifo level above depth");
endmodule : isf_status

// ==== core/isf_pkg.sv ====
// constants and register map of the two-wire interrupt status flags
// How it works
// [R1] start or restart sets start flag, bit 10
// [R2] stop condition sets stop flag, bit 9
// [R3] activity flag sets, sticks after idle
// [R4] activity clears: disable, two clear reads, reset
// [R5] slave transmit nack sets done flag, bit 7
// [R6] transmit failure sets abort flag, bit 6
// [R7] abort cause latched for software read
// [R8] abort flushes fifo until abort clear read
// [R9] remote master read sets request flag, bit 5
// [R10] pending read request holds clock low
// [R11] processor answers request via data port
// [R12] read request clear read drops flag
// [R13] level at or below threshold sets bit 4
// [R14] level above threshold clears bit 4
// [R15] disabled: fifo flushed, bit 4 follows activity
// [R16] idle with enable low drives bit 4 low
// [R17] write into full fifo sets overflow, bit 3
// [R18] overflow holds until internal enable drops; the combined clear read also clears it
// [R19] mask register gates the masked status
// [R20] flags zero after reset, status unwritable
package isf_pkg;
    localparam int unsigned ADDR_W = 32;
    localparam int unsigned DATA_W = 16;
    // register byte addresses
    localparam logic [31:0] ADDR_DATA_CMD = 32'h50001310;
    localparam logic [31:0] ADDR_ENABLE = 32'h5000136C;
    localparam logic [31:0] ADDR_TX_THRESH = 32'h5000133C;
    localparam logic [31:0] ADDR_MASKED_STAT = 32'h5000132C;
    localparam logic [31:0] ADDR_INTR_MASK = 32'h50001330;
    localparam logic [31:0] ADDR_RAW_STAT = 32'h50001334;
    localparam logic [31:0] ADDR_CLR_COMBINED = 32'h50001340;
    localparam logic [31:0] ADDR_CLR_RD_REQ = 32'h50001350;
    localparam logic [31:0] ADDR_CLR_TX_ABORT = 32'h50001354;
    localparam logic [31:0] ADDR_CLR_ACTIVITY = 32'h5000135C;
    localparam logic [31:0] ADDR_ABORT_CAUSE = 32'h50001380;
    // status bit positions
    localparam int unsigned BIT_START = 10;
    localparam int unsigned BIT_STOP = 9;
    localparam int unsigned BIT_ACTIVITY = 8;
    localparam int unsigned BIT_TX_DONE = 7;
    localparam int unsigned BIT_TX_ABORT = 6;
    localparam int unsigned BIT_RD_REQ = 5;
    localparam int unsigned BIT_TX_LOW = 4;
    localparam int unsigned BIT_TX_OVER = 3;
    // transmit fifo
    localparam int unsigned FIFO_DEPTH = 32;
    localparam int unsigned PTR_W = 5;
    localparam int unsigned LVL_W = 6;
    localparam logic [5:0] FIFO_FULL_LVL = 6'h20;
    localparam logic [5:0] LVL_ZERO = 6'h00;
    localparam logic [5:0] LVL_ONE = 6'h01;
    localparam logic [4:0] PTR_ONE = 5'h01;
    // reset values
    localparam logic [15:0] MASK_RESET = 16'h0FFF & 16'h08FF;
    localparam logic [4:0] THRESH_RESET = 5'h00;
    localparam logic [15:0] CAUSE_RESET = 16'h0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] STAT_USED = 16'h07F8;
endpackage : isf_pkg

// ==== tb/isf_core_model.sv ====
// far-side bus controller core model feeding events into the flags block
`timescale 1ns/100ps
module isf_core_model (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // fifo view
    input wire logic [5:0] tx_level,
    input wire logic tx_flushed,
    // events towards the flags block
    output logic core_start_seen,
    output logic core_stop_seen,
    output logic core_busy,
    output logic core_slave_tx_nack,
    output logic core_tx_abort,
    output logic [15:0] core_abort_cause,
    output logic core_read_request,
    output logic core_tx_pop
);
    initial begin
        {core_start_seen, core_stop_seen, core_slave_tx_nack} = 3'h0;
        {core_tx_abort, core_read_request, core_tx_pop, core_busy} = 4'h0;
        core_abort_cause = 16'hA5C3;
    end
    // kind: 0 start, 1 stop, 2 nack, 3 read request, 4 abort
    task automatic pulse(input int kind, input logic [15:0] cause);
        logic [4:0] ev;
        ev = 5'h10 >> kind;
        @(negedge clock);
        {core_start_seen, core_stop_seen, core_slave_tx_nack} = ev[4:2];
        {core_read_request, core_tx_abort} = ev[1:0];
        core_abort_cause = cause;
        @(negedge clock);
        {core_start_seen, core_stop_seen, core_slave_tx_nack} = 3'h0;
        {core_read_request, core_tx_abort} = 2'h0;
        // cause is only meaningful with the pulse, so scramble it afterwards
        core_abort_cause = ~cause;
    endtask : pulse
    task automatic set_busy(input logic b);
        @(negedge clock);
        core_busy = b;
    endtask : set_busy
    // pops only what is really there, and never two edges in a row
    task automatic pop_one();
        @(negedge clock);
        core_tx_pop = (tx_level != 6'h00) && !tx_flushed;
        @(negedge clock);
        core_tx_pop = 1'b0;
        @(negedge clock);
    endtask : pop_one
endmodule : isf_core_model

// ==== tb/test_isf_status.sv ====
// self-checking bench for the interrupt status flags block
`timescale 1ns/100ps
module test_isf_status;
    localparam logic [16:0] SKIP = 17'h10000;
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic reg_rd = 1'b0;
    logic reg_wr = 1'b0;
    logic [31:0] reg_addr = 32'h00000000;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata, masked_interrupt_status, core_abort_cause, cause;
    logic core_start_seen, core_stop_seen, core_busy, core_slave_tx_nack;
    logic core_tx_abort, core_read_request, core_tx_pop;
    logic [7:0] tx_head;
    logic [7:0] last_byte = 8'h00;
    logic [5:0] tx_level;
    logic tx_flushed, internal_enable_signal, scl_hold_low;
    logic rd_taken = 1'b0;
    logic [16:0] exp_q[$];
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;
    int i;
    always #10 clock = ~clock;
    isf_status i_dut (.clock(clock), .rst_n(rst_n), .reg_rd(reg_rd), .reg_wr(reg_wr),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .core_start_seen(core_start_seen), .core_stop_seen(core_stop_seen),
        .core_busy(core_busy), .core_slave_tx_nack(core_slave_tx_nack),
        .core_tx_abort(core_tx_abort), .core_abort_cause(core_abort_cause),
        .core_read_request(core_read_request), .core_tx_pop(core_tx_pop),
        .tx_head(tx_head), .tx_level(tx_level), .tx_flushed(tx_flushed),
        .internal_enable_signal(internal_enable_signal), .scl_hold_low(scl_hold_low),
        .masked_interrupt_status(masked_interrupt_status));
    isf_core_model i_core (.clock(clock), .rst_n(rst_n), .tx_level(tx_level),
        .tx_flushed(tx_flushed), .core_start_seen(core_start_seen),
        .core_stop_seen(core_stop_seen), .core_busy(core_busy),
        .core_slave_tx_nack(core_slave_tx_nack), .core_tx_abort(core_tx_abort),
        .core_abort_cause(core_abort_cause), .core_read_request(core_read_request),
        .core_tx_pop(core_tx_pop));
    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        total_checks++;
        if (seen !== want) begin
            error_cnt++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask : check
    task automatic test_done();
        $display("checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : test_done
    // the expected read word is queued here and compared by the monitor
    task automatic rd(input logic [31:0] addr, input logic [16:0] want);
        @(negedge clock);
        reg_rd = 1'b1;
        reg_addr = addr;
        exp_q.push_back(want);
        @(negedge clock);
        reg_rd = 1'b0;
    endtask : rd
    task automatic wr(input logic [31:0] addr, input logic [15:0] data);
        @(negedge clock);
        reg_wr = 1'b1;
        reg_addr = addr;
        reg_wdata = data;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask : wr
    task automatic wr_byte();
        last_byte = 8'($urandom());
        wr(isf_pkg::ADDR_DATA_CMD, {8'h00, last_byte});
    endtask : wr_byte
    task automatic settle();
        repeat (3) @(negedge clock);
    endtask : settle
    always @(posedge clock) begin
        rd_taken <= reg_rd;
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            error_cnt++;
            test_done();
        end
    end
    // read data stands for one cycle only, so it is taken mid-cycle
    always @(negedge clock) begin
        logic [16:0] want;
        if (rd_taken) begin
            want = exp_q.pop_front();
            if (!want[16]) check(reg_rdata, want[15:0]);
        end
    end
    initial begin
        void'($urandom(21));
        repeat (10) @(negedge clock);
        rst_n = 1'b1;
        rd(isf_pkg::ADDR_RAW_STAT, 17'h00000);
        rd(isf_pkg::ADDR_INTR_MASK, 17'h008FF);
        wr(isf_pkg::ADDR_RAW_STAT, 16'hFFFF);
        wr(isf_pkg::ADDR_MASKED_STAT, 16'hFFFF);
        rd(isf_pkg::ADDR_MASKED_STAT, 17'h00000);
        rd(32'h50001390, 17'h00000);
        rd(isf_pkg::ADDR_RAW_STAT, 17'h00000);
        wr(isf_pkg::ADDR_ENABLE, 16'h0001);
        settle();
        rd(isf_pkg::ADDR_RAW_STAT, 17'h00010);
        for (i = 0; i < 2; i++) begin
            i_core.set_busy(1'b1);
            i_core.pulse(0, 16'h0000);
            i_core.pulse(1, 16'h0000);
            rd(isf_pkg::ADDR_RAW_STAT, 17'h00710);
            i_core.set_busy(1'b0);
            settle();
            rd(isf_pkg::ADDR_RAW_STAT, 17'h00710);
            rd(i == 0 ? isf_pkg::ADDR_CLR_ACTIVITY : isf_pkg::ADDR_CLR_COMBINED,
                i == 0 ? 17'h00001 : SKIP);
            rd(isf_pkg::ADDR_RAW_STAT, i == 0 ? 17'h00610 : 17'h00010);
            rd(isf_pkg::ADDR_CLR_COMBINED, SKIP);
        end
        i_core.pulse(2, 16'h0000);
        rd(isf_pkg::ADDR_RAW_STAT, 17'h00090);
        rd(isf_pkg::ADDR_CLR_COMBINED, SKIP);
        wr(isf_pkg::ADDR_TX_THRESH, 16'h0001);
        wr_byte();
        cause = {8'h00, last_byte};
        wr_byte();
        check({8'h00, tx_head}, cause);
        rd(isf_pkg::ADDR_RAW_STAT, 17'h00000);
        i_core.pop_one();
        rd(isf_pkg::ADDR_RAW_STAT, 17'h00010);
        for (i = 0; i < 31; i++) wr_byte();
        settle();
        check({10'h000, tx_level}, 16'h0020);
        rd(isf_pkg::ADDR_RAW_STAT, 17'h00000);
        wr_byte();
        rd(isf_pkg::ADDR_RAW_STAT, 17'h00008);
        i_core.set_busy(1'b1);
        wr(isf_pkg::ADDR_ENABLE, 16'h0000);
        settle();
        check({10'h000, tx_level}, 16'h0000);
        rd(isf_pkg::ADDR_RAW_STAT, 17'h00118);
        i_core.set_busy(1'b0);
        settle();
        check({15'h0000, internal_enable_signal}, 16'h0000);
        rd(isf_pkg::ADDR_RAW_STAT, 17'h00000);
        wr(isf_pkg::ADDR_ENABLE, 16'h0001);
        wr_byte();
        cause = 16'($urandom());
        i_core.pulse(4, cause);
        settle();
        check({15'h0000, tx_flushed}, 16'h0001);
        rd(isf_pkg::ADDR_RAW_STAT, 17'h00050);
        rd(isf_pkg::ADDR_ABORT_CAUSE, {1'b0, cause});
        wr_byte();
        settle();
        check({10'h000, tx_level}, 16'h0000);
        rd(isf_pkg::ADDR_CLR_TX_ABORT, 17'h00001);
        wr_byte();
        settle();
        check({10'h000, tx_level}, 16'h0001);
        rd(isf_pkg::ADDR_ABORT_CAUSE, 17'h00000);
        i_core.pulse(3, 16'h0000);
        settle();
        rd(isf_pkg::ADDR_RAW_STAT, 17'h00030);
        wr_byte();
        settle();
        check({15'h0000, scl_hold_low}, 16'h0001);
        rd(isf_pkg::ADDR_CLR_RD_REQ, 17'h00001);
        settle();
        check({15'h0000, scl_hold_low}, 16'h0000);
        i_core.pulse(0, 16'h0000);
        wr(isf_pkg::ADDR_INTR_MASK, 16'h0400);
        settle();
        check(masked_interrupt_status, 16'h0400);
        wr(isf_pkg::ADDR_INTR_MASK, 16'h0200);
        settle();
        check(masked_interrupt_status, 16'h0000);
        check(16'(exp_q.size()), 16'h0000);
        test_done();
    end
endmodule : test_isf_status
